// ==== inc/vxq_pkg.sv ====
// constants, types and table lookup for the extended query table
package vxq_pkg;

  // query address space
  localparam int          QRY_ADDR_W = 9;
  localparam logic [8:0]  QRY_BASE   = 9'h10a;
  localparam logic [7:0]  TBL_LEN    = 8'h1d;

  // byte offsets from the table base
  localparam logic [7:0]  OFS_SIG    = 8'h00;
  localparam logic [7:0]  OFS_VER    = 8'h03;
  localparam logic [7:0]  OFS_FEAT   = 8'h05;
  localparam logic [7:0]  OFS_SUSP   = 8'h09;
  localparam logic [7:0]  OFS_BLK    = 8'h0a;
  localparam logic [7:0]  OFS_VCC    = 8'h0c;
  localparam logic [7:0]  OFS_VPP    = 8'h0d;
  localparam logic [7:0]  OFS_PCNT   = 8'h0e;
  localparam logic [7:0]  OFS_DESC1  = 8'h0f;
  localparam logic [7:0]  OFS_DESC2  = 8'h13;

  // signature and version, ascii
  localparam logic [23:0] SIG_STR    = 24'h49_52_50;
  localparam logic [15:0] VER_STR    = 16'h34_31;

  // optional feature bit positions
  localparam int FEAT_CHIP_ERASE  = 0;
  localparam int FEAT_SUSP_ERASE  = 1;
  localparam int FEAT_SUSP_PROG   = 2;
  localparam int FEAT_LEGACY_LOCK = 3;
  localparam int FEAT_QUEUED_ERS  = 4;
  localparam int FEAT_INST_LOCK   = 5;
  localparam int FEAT_PROT_BITS   = 6;
  localparam int FEAT_PAGE_READ   = 7;
  localparam int FEAT_SYNC_READ   = 8;
  localparam int FEAT_SIMUL_OPS   = 9;
  localparam int FEAT_EXT_ARRAY   = 10;
  localparam int FEAT_CHAIN       = 31;

  // supported features only; absent and reserved bits stay zero
  // chain bit 31 stays clear, so no second field follows
  localparam logic [31:0] FEAT_MAP =
    (32'h1 << FEAT_SUSP_ERASE) | (32'h1 << FEAT_SUSP_PROG) |
    (32'h1 << FEAT_INST_LOCK)  | (32'h1 << FEAT_PROT_BITS) |
    (32'h1 << FEAT_PAGE_READ)  | (32'h1 << FEAT_SYNC_READ);

  // suspend operations and block status mask
  localparam logic [7:0]  SUSP_OPS   = 8'h01;
  localparam logic [15:0] BLK_MASK   = 16'h0003;

  // supply voltages: whole volts and tenths
  localparam logic [3:0]  VCC_VOLTS  = 4'h1;
  localparam logic [3:0]  VCC_TENTHS = 4'h8;
  localparam logic [3:0]  VPP_VOLTS  = 4'h9;
  localparam logic [3:0]  VPP_TENTHS = 4'h0;

  // protection descriptors, least significant byte first
  localparam logic [7:0]  PROT_COUNT = 8'h02;
  localparam logic [31:0] DESC1      = 32'h03_03_0000 | 32'h80;
  localparam logic [31:0] D2_LOCK    = 32'h0000_0089;
  localparam logic [15:0] D2_FGRP    = 16'h0000;
  localparam logic [7:0]  D2_FLOG    = 8'h00;
  localparam logic [15:0] D2_UGRP    = 16'h0010;
  localparam logic [7:0]  D2_ULOG    = 8'h04;
  localparam logic [79:0] DESC2 =
    {D2_ULOG, D2_UGRP, D2_FLOG, D2_FGRP, D2_LOCK};

  // read request and answer carriers
  typedef struct packed {
    logic                  rd;
    logic [QRY_ADDR_W-1:0] addr;
  } vxq_req_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } vxq_rsp_s;

  // pack a voltage into one byte, volts high nibble, tenths low
  function automatic logic [7:0] volt_byte(input logic [3:0] volts,
                                           input logic [3:0] tenths);
    return {volts, tenths};
  endfunction

  // table byte at an offset from the base; zero outside the table
  function automatic logic [7:0] tbl_byte(input logic [7:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    if (ofs < OFS_VER)
      b = SIG_STR[8*ofs[1:0] +: 8];
    else if (ofs < OFS_FEAT)
      b = VER_STR[8*(ofs[0] ^ OFS_VER[0]) +: 8];
    else if (ofs < OFS_SUSP)
      b = FEAT_MAP[8*(2'(ofs - OFS_FEAT)) +: 8];
    else if (ofs == OFS_SUSP)
      b = SUSP_OPS;
    else if (ofs < OFS_VCC)
      b = BLK_MASK[8*(ofs[0] ^ OFS_BLK[0]) +: 8];
    else if (ofs == OFS_VCC)
      b = volt_byte(VCC_VOLTS, VCC_TENTHS);
    else if (ofs == OFS_VPP)
      b = volt_byte(VPP_VOLTS, VPP_TENTHS);
    else if (ofs == OFS_PCNT)
      b = PROT_COUNT;
    else if (ofs < OFS_DESC2)
      b = DESC1[8*(2'(ofs - OFS_DESC1)) +: 8];
    else if (ofs < TBL_LEN)
      b = DESC2[8*(4'(ofs - OFS_DESC2)) +: 8];
    return b;
  endfunction

endpackage

// ==== hdl/vxq_rom.sv ====
// registered lookup of the query table bytes
`timescale 1ns/1ps
module vxq_rom
  import vxq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire vxq_req_s   req,
  output      vxq_rsp_s   rsp
);

  logic       in_table;
  logic [7:0] ofs;
  vxq_rsp_s   rsp_reg;
  vxq_rsp_s   rsp_next;

  // window decode; addresses outside the table answer zero
  assign in_table = (req.addr >= QRY_BASE) &&
                    (req.addr < (QRY_BASE + 9'(TBL_LEN)));
  assign ofs      = 8'(req.addr - QRY_BASE);
  // one assignment for the whole carrier keeps a single driver
  assign rsp_next = '{valid: req.rd,
                      data:  in_table ? tbl_byte(ofs) : 8'h00};

  // data leaves through a register so timing is fixed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

endmodule

// ==== hdl/vxq_table.sv ====
// query-mode reader of the vendor extended query table
`timescale 1ns/1ps
// Behaviour
// - bytes 50h 52h 49h at 10Ah, 10Bh, 10Ch open the extended table.
// - major version 31h at 10Dh, minor version 34h at 10Eh.
// - feature bitmap bytes E6h 01h 00h 00h at 10Fh to 112h.
// - suspend, instant locking, protection, page, sync reads set; others clear.
// - bitmap bits 10 to 31 zero; bit 31 would chain another field.
// - 01h at 113h, program allowed in erase suspend, upper bits zero.
// - block status mask 03h 00h at 114h, lock and lock-down only.
// - logic supply byte is BCD volts and tenths, giving 1.8 V.
// - programming supply byte at 117h gives 9.0 V, tenths in BCD.
// - 02h at 118h counts descriptors; zero would mean 256.
// - first descriptor 80h 00h 03h 03h at 119h to 11Ch.
// - second descriptor fields sit at bits 32, 48, 56 and 72.
module vxq_table
  import vxq_pkg::*;
#(
  parameter int DQ_W = 16
)
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  input  wire logic                  QRY_MODE,
  input  wire logic                  QRY_RD,
  input  wire logic [QRY_ADDR_W-1:0] QRY_ADDR,
  output      logic                  QRY_READY,
  output      logic                  DQ_VALID,
  output      logic [DQ_W-1:0]       DQ_OUT
);

  // the byte lane must fit on the data bus
  if (DQ_W < 8 || DQ_W > 32) begin : g_dq_check
    $error("DQ_W must lie between 8 and 32");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_LOOK  = 3'h2,
    ST_DRIVE = 3'h4
  } vxq_state_e;

  logic             rst_s1_reg;
  logic             rst_s2_reg;
  logic             rst_n;
  vxq_state_e       state_reg;
  vxq_state_e       state_next;
  vxq_req_s         req;
  vxq_rsp_s         rsp;
  logic             take;
  logic             look;
  logic             valid_reg;
  logic [DQ_W-1:0]  dq_reg;
  logic [DQ_W-1:0]  dq_next;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign rst_n = rst_s2_reg;

  // one read in flight; busy cycles refuse new reads
  assign QRY_READY = (state_reg == ST_IDLE);
  assign take      = QRY_READY && QRY_MODE && QRY_RD;
  assign req       = '{rd: take, addr: QRY_ADDR}; // word address

  // table bytes come from the lookup
  vxq_rom u_rom (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .req   (req),
    .rsp   (rsp)
  );

  // sequencing of one lookup
  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = take ? ST_LOOK : ST_IDLE;
      ST_LOOK:  state_next = ST_DRIVE;
      ST_DRIVE: state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // answer only when the lookup really saw a taken read
  assign look    = (state_reg == ST_LOOK) && rsp.valid;

  // byte on the low lane, upper lanes forced to zero
  assign dq_next = look ? {{(DQ_W-8){1'b0}}, rsp.data} : dq_reg;

  // data holds until the next read so slow hosts still see it
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      valid_reg <= 1'b0;
      dq_reg    <= '0;
    end else begin
      state_reg <= state_next;
      valid_reg <= look;
      dq_reg    <= dq_next;
    end
  end

  assign DQ_VALID = valid_reg;
  assign DQ_OUT   = dq_reg;

  // checks on the answer, all in the internal reset domain
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_take(logic [8:0] a);
    take && (QRY_ADDR == a);
  endsequence

  sequence s_answer(logic [7:0] b);
    ##2 (DQ_VALID && (DQ_OUT[7:0] == b));
  endsequence

  property p_sig;
    s_take(9'h10a) |-> s_answer(8'h50) ##0 $past(take, 2);
  endproperty
  a_sig: assert property (p_sig)
    else $error("signature byte wrong at table base");

  property p_major;
    s_take(9'h10d) |-> s_answer(8'h31);
  endproperty
  a_major: assert property (p_major)
    else $error("major version byte wrong");

  property p_ver;
    s_take(9'h10e) |-> s_answer(8'h34);
  endproperty
  a_ver: assert property (p_ver)
    else $error("minor version byte wrong");

  property p_feat;
    s_take(9'h10f) |-> s_answer(8'he6);
  endproperty
  a_feat: assert property (p_feat)
    else $error("feature bitmap low byte wrong");

  property p_feat_hi;
    (take && QRY_ADDR inside {9'h111, 9'h112}) |-> s_answer(8'h00);
  endproperty
  a_feat_hi: assert property (p_feat_hi)
    else $error("reserved feature bits not zero");

  property p_sync;
    s_take(9'h110) |-> ##2 (DQ_VALID && DQ_OUT[0] && !DQ_OUT[1]);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync read or simultaneous ops bit wrong");

  property p_susp;
    s_take(9'h113) |-> s_answer(8'h01);
  endproperty
  a_susp: assert property (p_susp)
    else $error("suspend operations byte wrong");

  property p_blk;
    s_take(9'h114) |-> s_answer(8'h03);
  endproperty
  a_blk: assert property (p_blk)
    else $error("block status mask wrong");

  property p_vcc;
    s_take(9'h116) |-> s_answer(8'h18);
  endproperty
  a_vcc: assert property (p_vcc)
    else $error("logic supply voltage byte wrong");

  property p_vpp;
    s_take(9'h117) |-> s_answer(8'h90);
  endproperty
  a_vpp: assert property (p_vpp)
    else $error("programming supply voltage byte wrong");

  property p_pcnt;
    s_take(9'h118) |-> s_answer(8'h02);
  endproperty
  a_pcnt: assert property (p_pcnt)
    else $error("descriptor count wrong");

  property p_desc1;
    s_take(9'h11b) |-> s_answer(8'h03);
  endproperty
  a_desc1: assert property (p_desc1)
    else $error("first descriptor factory size wrong");

  property p_desc2;
    s_take(9'h11d) |-> s_answer(8'h89);
  endproperty
  a_desc2: assert property (p_desc2)
    else $error("second descriptor lock word wrong");

  property p_ugrp;
    s_take(9'h124) |-> s_answer(8'h10);
  endproperty
  a_ugrp: assert property (p_ugrp)
    else $error("user group count misplaced");

  property p_lane;
    DQ_VALID |-> (DQ_OUT[DQ_W-1:8] == '0) && $past(take, 2);
  endproperty
  a_lane: assert property (p_lane)
    else $error("upper lanes driven or answer without read");

  property p_busy;
    take |=> !QRY_READY [*2] ##1 QRY_READY;
  endproperty
  a_busy: assert property (p_busy)
    else $error("read spacing not three cycles");

endmodule

// ==== tb/vxq_host.sv ====
// host model issuing query reads to the table
`timescale 1ns/1ps
module vxq_host
  import vxq_pkg::*;
#(
  parameter int DQ_W = 16
)
(
  input  wire logic                  clk,
  input  wire logic                  ready,
  input  wire logic                  valid,
  input  wire logic [DQ_W-1:0]       dq,
  output      logic                  mode,
  output      logic                  rd,
  output      logic [QRY_ADDR_W-1:0] addr
);
  initial begin
    mode = 1'b0;
    rd = 1'b0;
    addr = '0;
  end

  // one read; request held until an edge that finds ready high
  task automatic read(input logic [QRY_ADDR_W-1:0] a, input logic m,
                      output logic [DQ_W-1:0] d, output int lat,
                      output int np);
    int n;
    lat = -1;
    np = 0;
    d = '0;
    @(posedge clk);
    rd <= 1'b1;
    mode <= m;
    addr <= a;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 8);
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a; // released lines must not keep the last value
    // answer window; counting pulses catches a stuck valid
    for (n = 1; n <= 4; n++) begin
      @(negedge clk);
      if (valid === 1'b1) begin
        np++;
        if (lat < 0) begin
          lat = n;
          d = dq;
        end
      end
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the extended query table
`timescale 1ns/1ps
module tb;
  import vxq_pkg::*;
  localparam int DQ_W = 16;
  // expected image, byte at 10Ah lowest
  localparam logic [231:0] IMG = {
    96'h04_00_10_00_00_00_00_00_00_89_03_03,
    136'h00_80_02_90_18_00_03_01_00_00_01_e6_34_31_49_52_50};
  logic            ref_clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            qry_mode;
  logic            qry_rd;
  logic [8:0]      qry_addr;
  logic            qry_ready;
  logic            dq_valid;
  logic [DQ_W-1:0] dq_out;
  logic [DQ_W-1:0] d;
  logic [8:0]      a;
  logic            m;
  int              lat;
  int              np;
  int              fails = 0;
  int              checked = 0;
  int              seed = 91470;

  always #12.5 ref_clk = ~ref_clk;

  vxq_table #(.DQ_W(DQ_W)) vxq_table_i (
    .REF_CLK(ref_clk), .RST_B(rst_b), .QRY_MODE(qry_mode),
    .QRY_RD(qry_rd), .QRY_ADDR(qry_addr), .QRY_READY(qry_ready),
    .DQ_VALID(dq_valid), .DQ_OUT(dq_out));

  vxq_host #(.DQ_W(DQ_W)) vxq_host_i (
    .clk(ref_clk), .ready(qry_ready), .valid(dq_valid), .dq(dq_out),
    .mode(qry_mode), .rd(qry_rd), .addr(qry_addr));

  // expected word: byte low, upper lines zero, 00h outside the table
  function automatic logic [DQ_W-1:0] exp_dq(input logic [8:0] x);
    logic [8:0] o;
    o = x - 9'h10a;
    if (x < 9'h10a || x > 9'h126)
      return '0;
    return {8'h00, IMG[8*o +: 8]};
  endfunction

  task automatic chk_dq(input logic [DQ_W-1:0] g, input logic [DQ_W-1:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_cnt(input int g, input int e);
    checked++;
    if (g != e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // reads take five cycles; this is ample margin
  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // whole table and both neighbours
    for (int i = 9'h108; i <= 9'h128; i++) begin
      vxq_host_i.read(9'(i), 1'b1, d, lat, np);
      chk_dq(d, exp_dq(9'(i)));
      chk_dq(d, exp_dq(9'(i)));
      chk_cnt(lat, 2);
      chk_cnt(np, 1);
    end
    $display("test sweep done");
    // refused read leaves the sweep's last answer (128h) standing
    vxq_host_i.read(9'h126, 1'b0, d, lat, np);
    chk_cnt(lat, -1);
    chk_dq(dq_out, exp_dq(9'h128));
    $display("test refusal done");
    // random addresses, query mode mostly on
    for (int i = 0; i < 200; i++) begin
      a = 9'($random(seed));
      m = ($random(seed) & 3) != 0;
      vxq_host_i.read(a, m, d, lat, np);
      chk_cnt(lat, m ? 2 : -1);
      if (m) chk_dq(d, exp_dq(a));
    end
    $display("test random done");
    // reset in mid-run clears the answer
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_dq(dq_out, '0);
    chk_dq({{(DQ_W-2){1'b0}}, dq_valid, qry_ready}, DQ_W'(1));
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    vxq_host_i.read(9'h10a, 1'b1, d, lat, np);
    chk_dq(d, exp_dq(9'h10a));
    $display("test reset done");
    conclude();
  end
endmodule
